// [include/flash_pkg.sv]
package flash_pkg;
	// ************************************************
	// Clock and operation timing
	// ************************************************
	localparam int CLK_NS = 4;
	localparam int SRW_NS = 1000;
	localparam int PROG_NS = 2000;
	localparam int WIPE_NS = 8000;
	localparam logic [15:0] SRW_CYC = 16'(SRW_NS / CLK_NS);
	localparam logic [15:0] PROG_CYC = 16'(PROG_NS / CLK_NS);
	localparam logic [15:0] WIPE_CYC = 16'(WIPE_NS / CLK_NS);
	localparam logic [3:0] SCK_HALF = 4'h8;

	// ************************************************
	// Instruction codes
	// ************************************************
	localparam logic [7:0] OP_LATCH_SET = 8'h06;
	localparam logic [7:0] OP_LATCH_CLR = 8'h04;
	localparam logic [7:0] OP_VOL_EN = 8'h50;
	localparam logic [7:0] OP_SR_LO = 8'h05;
	localparam logic [7:0] OP_SR_HI = 8'h35;
	localparam logic [7:0] OP_SRW = 8'h01;
	localparam logic [7:0] OP_SRW_HI = 8'h31;
	localparam logic [7:0] OP_PAGE = 8'h02;
	localparam logic [7:0] OP_SMALL = 8'h20;
	localparam logic [7:0] OP_BLOCK = 8'hD8;
	localparam logic [7:0] OP_ARRAY = 8'hC7;
	localparam logic [7:0] OP_SEC_WIPE = 8'h44;
	localparam logic [7:0] OP_SEC_WR = 8'h42;
	localparam logic [7:0] OP_PAUSE = 8'h75;
	localparam logic [7:0] OP_RESUME = 8'h7A;
	localparam logic [7:0] OP_RST_EN = 8'h66;
	localparam logic [7:0] OP_RST = 8'h99;
	localparam logic [7:0] OP_QUAD_ON = 8'h38;
	localparam logic [7:0] OP_QUAD_OFF = 8'hFF;

	// ************************************************
	// Status layout
	// ************************************************
	localparam int B_BUSY = 0;
	localparam int B_LATCH = 1;
	localparam int B_PR_LO = 2;
	localparam int B_PR_HI = 6;
	localparam int B_LOCK_LO = 7;
	localparam int B_LOCK_HI = 8;
	localparam int B_QUAD = 9;
	localparam int B_FAIL = 10;
	localparam int B_SEC_LO = 11;
	localparam int B_SEC_HI = 13;
	localparam int B_CMP = 14;
	localparam int B_PAUSE = 15;
	localparam logic [15:0] SRW_MASK = 16'h7BFC;
	localparam logic [15:0] SEC_MASK = 16'h3800;
	localparam logic [1:0] LOCK_SW = 2'h0;
	localparam logic [1:0] LOCK_HW = 2'h1;
	localparam logic [5:0] SEC1_CODE = 6'h04;
	localparam logic [5:0] SEC2_CODE = 6'h08;
	localparam logic [5:0] SEC3_CODE = 6'h0C;
	localparam logic [5:0] BITS_OP = 6'h08;
	localparam logic [5:0] BITS_SR1 = 6'h10;
	localparam logic [5:0] BITS_SR2 = 6'h18;
	localparam logic [5:0] BITS_ADR = 6'h20;
	localparam logic [5:0] BITS_DATA = 6'h28;
	localparam logic [5:0] BITS_SAT = 6'h3B;
	localparam int SO_IO = 1;
	localparam int GUARD_IO = 2;
	localparam int PAUSE_IO = 3;

	// ************************************************
	// Controller registers
	// ************************************************
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_TX = 8'h04;
	localparam logic [7:0] REG_RX = 8'h08;
	localparam logic [7:0] REG_STAT = 8'h0C;
	localparam int F_TX_LO = 8;
	localparam int F_RX_LO = 11;
	localparam int CTRL_QUAD = 14;
	localparam int CTRL_GUARD = 15;
	localparam int CTRL_GO = 31;
	localparam int STAT_RUN = 0;
	localparam int STAT_REFUSED = 1;
	localparam int STAT_DEVBUSY = 2;
endpackage

// [include/flash_link_if.sv]
`timescale 1ns/1ps
interface flash_link_if;
	logic cs_n;
	logic sck;
	logic [3:0] h_o;
	logic [3:0] h_oe_n;
	logic [3:0] d_o;
	logic [3:0] d_oe_n;
	logic [3:0] io;

	// Wire level: host wins, then device, else pulled high
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			io[i] = !h_oe_n[i] ? h_o[i] : (!d_oe_n[i] ? d_o[i] : 1'b1);
		end
	end

	modport host (output cs_n, output sck, output h_o, output h_oe_n, input io);
	modport dev (input cs_n, input sck, input io, output d_o, output d_oe_n);
endinterface

// [hdl/pin_sync.sv]
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	logic [W-1:0] meta_q;

	// Two stages; the first is read only by the second
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			meta_q <= INIT;
			o_sync <= INIT;
		end else begin
			meta_q <= i_async;
			o_sync <= meta_q;
		end
	end
endmodule

// [hdl/flash_status_dev.sv]
`timescale 1ns/1ps
// Functional notes
// RULE1: Instruction 06H sets the write latch
// RULE2: Host frames latch commands as lone byte
// RULE3: Instruction 04H clears the write latch
// RULE4: Latch clears after completions, power-up, reset
// RULE5: Host re-sends latch set before changes
// RULE6: Latch clear rejects status write, program, erase
// RULE7: 50H enables volatile-only status write
// RULE8: 05H shifts low byte, 35H high
// RULE9: Status reads always allowed; upper lines ignored
// RULE10: Host polls busy before new instruction
// RULE11: Busy bit high during program, erase, write
// RULE12: Sixteen-bit status layout, all reset zero
// RULE13: Range bits protect region from changes
// RULE14: Array wipe only with nothing protected
// RULE15: Lock modes 00/01 with guard pin
// RULE16: Lock 10 until power cycle, 11 forever; i_reset clears both here
// RULE17: Quad flag turns guard, pause into data
// RULE18: Fail flag on failure, reset, protected target
// RULE19: Security lock bits are one-time set
// RULE20: Pause flag set by 75H, cleared 7AH
// RULE21: Four-wire mode moves nibbles, high first
// RULE22: Security register address decode
module flash_status_dev (
	flash_link_if.dev link,
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic i_op_fault,
	output logic [15:0] o_status,
	output logic o_quad_cmd
);
	logic [5:0] pins_s;
	logic cs_s;
	logic sck_s;
	logic [3:0] io_s;
	logic cs_prev_q;
	logic sck_prev_q;
	logic hold;
	logic cs_rise;
	logic sck_rise;
	logic sck_fall;
	logic [39:0] in_q;
	logic [39:0] nxt_in;
	logic [5:0] bits_q;
	logic [5:0] step;
	logic [5:0] nbits;
	logic [7:0] op_q;
	logic [23:0] addr_q;
	logic rd_q;
	logic qpi_q;
	logic vol_q;
	logic arm_q;
	logic [15:0] sr_q;
	logic [15:0] nv_q;
	logic [15:0] bcnt_q;
	logic prog_q;
	logic [15:0] img;
	logic [15:0] sr_new;
	logic idle;
	logic one;
	logic srw_ok;
	logic srw_len;
	logic pe_len;
	logic pe_bad;
	logic [2:0] idx_q;
	logic [7:0] rd_byte;

	// ************************************************
	// Helpers
	// ************************************************
	localparam logic [5:0] SEC1_CODE_L = flash_pkg::SEC1_CODE;
	localparam logic [5:0] SEC2_CODE_L = flash_pkg::SEC2_CODE;
	localparam logic [5:0] SEC3_CODE_L = flash_pkg::SEC3_CODE;

	// Stand-in region map: top 2^(n-1) 64K blocks, inverted by complement
	function automatic logic prot_hit(input logic [4:0] bp, input logic cmp, input logic [23:0] a);
		logic hit;
		hit = (bp != 5'h00) && ({24'h000000, ~a[23:16]} < (32'h00000001 << (bp - 5'h01)));
		return hit ^ cmp;
	endfunction

	function automatic logic [1:0] sec_index(input logic [23:0] a);
		if (a[23:16] != 8'h00) return 2'h0;
		case (a[15:10])
			SEC1_CODE_L: return 2'h1;
			SEC2_CODE_L: return 2'h2;
			SEC3_CODE_L: return 2'h3;
			default: return 2'h0;
		endcase
	endfunction

	// ************************************************
	// Pin capture and edges
	// ************************************************
	pin_sync #(.W(6), .INIT(6'h20)) u_sync (
		.i_clk_sys(i_clk_sys),
		.i_reset(i_reset),
		.i_async({link.cs_n, link.sck, link.io}),
		.o_sync(pins_s)
	);
	assign cs_s = pins_s[5];
	assign sck_s = pins_s[4];
	assign io_s = pins_s[3:0];

	// Edge history
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			cs_prev_q <= 1'b1;
			sck_prev_q <= 1'b0;
		end else begin
			cs_prev_q <= cs_s;
			sck_prev_q <= sck_s;
		end
	end

	// Pause pin freezes the clock only in plain single-line use
	assign hold = !qpi_q && !sr_q[flash_pkg::B_QUAD] && !io_s[flash_pkg::PAUSE_IO]; // RULE17
	assign cs_rise = cs_s && !cs_prev_q;
	assign sck_rise = !cs_s && !hold && sck_s && !sck_prev_q;
	assign sck_fall = !cs_s && !hold && !sck_s && sck_prev_q;

	// ************************************************
	// Shift in
	// ************************************************
	assign step = qpi_q ? 6'h04 : 6'h01;
	// Quad takes a nibble, high first; single line reads IO0 only
	assign nxt_in = qpi_q ? {in_q[35:0], io_s} : {in_q[38:0], io_s[0]}; // RULE21 RULE9
	assign nbits = (bits_q > flash_pkg::BITS_SAT) ? bits_q : bits_q + step;

	// Opcode, address and read flag capture
	always_ff @(posedge i_clk_sys) begin
		if (i_reset || cs_s) begin
			bits_q <= 6'h00;
			rd_q <= 1'b0;
			if (i_reset) begin
				in_q <= '0;
				op_q <= 8'h00;
				addr_q <= 24'h000000;
			end
		end else if (sck_rise) begin
			in_q <= nxt_in;
			bits_q <= nbits;
			if (nbits == flash_pkg::BITS_OP) begin
				op_q <= nxt_in[7:0];
				rd_q <= (nxt_in[7:0] == flash_pkg::OP_SR_LO) || (nxt_in[7:0] == flash_pkg::OP_SR_HI);
			end
			if (nbits == flash_pkg::BITS_ADR) begin
				addr_q <= nxt_in[23:0];
			end
		end
	end

	// ************************************************
	// Command qualifiers
	// ************************************************
	assign idle = !sr_q[flash_pkg::B_BUSY] && !sr_q[flash_pkg::B_PAUSE];
	assign one = (bits_q == flash_pkg::BITS_OP);
	// Guard pin only counts while the quad flag is clear, even in four-wire mode
	assign srw_ok = (sr_q[flash_pkg::B_LATCH] || vol_q) && // RULE6 RULE7
		((sr_q[flash_pkg::B_LOCK_HI:flash_pkg::B_LOCK_LO] == flash_pkg::LOCK_SW) || // RULE15 RULE16
		((sr_q[flash_pkg::B_LOCK_HI:flash_pkg::B_LOCK_LO] == flash_pkg::LOCK_HW) &&
		(sr_q[flash_pkg::B_QUAD] || io_s[flash_pkg::GUARD_IO]))); // RULE13
	assign srw_len = (op_q == flash_pkg::OP_SRW_HI) ? (bits_q == flash_pkg::BITS_SR1) :
		((bits_q == flash_pkg::BITS_SR1) || (bits_q == flash_pkg::BITS_SR2));

	// New status image; a single low byte drops complement, quad, lock-high
	always_comb begin
		img = sr_q;
		if (op_q == flash_pkg::OP_SRW_HI) begin
			img[15:8] = in_q[7:0];
		end else if (bits_q == flash_pkg::BITS_SR2) begin
			img = {in_q[7:0], in_q[15:8]};
		end else begin
			img[7:0] = in_q[7:0];
			img[flash_pkg::B_CMP] = 1'b0;
			img[flash_pkg::B_QUAD] = 1'b0;
			img[flash_pkg::B_LOCK_HI] = 1'b0;
		end
		sr_new = (sr_q & ~flash_pkg::SRW_MASK) | (img & flash_pkg::SRW_MASK) | (sr_q & flash_pkg::SEC_MASK); // RULE19
	end

	// Program and erase length and target checks
	always_comb begin
		logic [1:0] si;
		logic [2:0] lk;
		si = sec_index(addr_q); // RULE22
		lk = sr_q[flash_pkg::B_SEC_HI:flash_pkg::B_SEC_LO];
		pe_len = 1'b0;
		pe_bad = 1'b0;
		case (op_q)
			flash_pkg::OP_PAGE: begin
				pe_len = bits_q >= flash_pkg::BITS_DATA;
				pe_bad = prot_hit(sr_q[flash_pkg::B_PR_HI:flash_pkg::B_PR_LO], sr_q[flash_pkg::B_CMP], addr_q); // RULE13
			end
			flash_pkg::OP_SMALL, flash_pkg::OP_BLOCK: begin
				pe_len = bits_q == flash_pkg::BITS_ADR;
				pe_bad = prot_hit(sr_q[flash_pkg::B_PR_HI:flash_pkg::B_PR_LO], sr_q[flash_pkg::B_CMP], addr_q); // RULE13
			end
			flash_pkg::OP_ARRAY: begin
				pe_len = one;
				pe_bad = (sr_q[flash_pkg::B_PR_HI:flash_pkg::B_PR_LO] != 5'h00) || sr_q[flash_pkg::B_CMP]; // RULE14
			end
			flash_pkg::OP_SEC_WIPE, flash_pkg::OP_SEC_WR: begin
				pe_len = (op_q == flash_pkg::OP_SEC_WR) ? (bits_q >= flash_pkg::BITS_DATA) : (bits_q == flash_pkg::BITS_ADR);
				pe_bad = (si == 2'h0) || lk[si - 2'h1]; // RULE19 RULE22
			end
			default: begin
				pe_len = 1'b0;
			end
		endcase
	end

	// ************************************************
	// Mode flags
	// ************************************************
	// Volatile enable and reset arm last only until the next frame
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			qpi_q <= 1'b0;
			vol_q <= 1'b0;
			arm_q <= 1'b0;
		end else if (cs_rise) begin
			vol_q <= one && (op_q == flash_pkg::OP_VOL_EN); // RULE7
			arm_q <= one && (op_q == flash_pkg::OP_RST_EN);
			if (one && (op_q == flash_pkg::OP_QUAD_ON)) begin
				qpi_q <= 1'b1;
			end else if (one && ((op_q == flash_pkg::OP_QUAD_OFF) || (op_q == flash_pkg::OP_RST && arm_q))) begin
				qpi_q <= 1'b0;
			end
		end
	end

	// ************************************************
	// Status engine
	// ************************************************
	// Later assignments override the countdown in the same cycle
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			sr_q <= 16'h0000; // RULE12 RULE16 RULE4 RULE20
			nv_q <= 16'h0000;
			bcnt_q <= 16'h0000;
			prog_q <= 1'b0;
		end else begin
			if (sr_q[flash_pkg::B_BUSY]) begin
				bcnt_q <= bcnt_q - 16'h0001;
				if (bcnt_q == 16'h0001) begin
					sr_q[flash_pkg::B_BUSY] <= 1'b0; // RULE11
					sr_q[flash_pkg::B_LATCH] <= 1'b0; // RULE4
					if (prog_q) begin
						sr_q[flash_pkg::B_FAIL] <= i_op_fault; // RULE18
					end
				end
			end
			if (cs_rise) begin
				case (op_q)
					flash_pkg::OP_LATCH_SET: if (idle && one) sr_q[flash_pkg::B_LATCH] <= 1'b1; // RULE1
					flash_pkg::OP_LATCH_CLR: if (idle && one) sr_q[flash_pkg::B_LATCH] <= 1'b0; // RULE3 RULE4
					flash_pkg::OP_SRW, flash_pkg::OP_SRW_HI: begin
						if (idle && srw_len && srw_ok) begin
							sr_q <= sr_new;
							// Volatile write: no cycle, copy kept for soft reset untouched
							if (!vol_q) begin // RULE7
								nv_q <= sr_new & flash_pkg::SRW_MASK;
								sr_q[flash_pkg::B_BUSY] <= 1'b1; // RULE11
								bcnt_q <= flash_pkg::SRW_CYC;
								prog_q <= 1'b0;
							end
						end
					end
					flash_pkg::OP_PAGE, flash_pkg::OP_SMALL, flash_pkg::OP_BLOCK, flash_pkg::OP_ARRAY,
					flash_pkg::OP_SEC_WIPE, flash_pkg::OP_SEC_WR: begin
						if (idle && pe_len && sr_q[flash_pkg::B_LATCH]) begin // RULE6
							if (pe_bad) begin
								sr_q[flash_pkg::B_FAIL] <= 1'b1; // RULE18
								sr_q[flash_pkg::B_LATCH] <= 1'b0;
							end else begin
								sr_q[flash_pkg::B_BUSY] <= 1'b1; // RULE11
								prog_q <= 1'b1;
								bcnt_q <= ((op_q == flash_pkg::OP_PAGE) || (op_q == flash_pkg::OP_SEC_WR)) ?
									flash_pkg::PROG_CYC : flash_pkg::WIPE_CYC;
							end
						end
					end
					flash_pkg::OP_PAUSE: begin
						if (one && sr_q[flash_pkg::B_BUSY] && prog_q) begin
							sr_q[flash_pkg::B_BUSY] <= 1'b0;
							sr_q[flash_pkg::B_PAUSE] <= 1'b1; // RULE20
						end
					end
					flash_pkg::OP_RESUME: begin
						if (one && sr_q[flash_pkg::B_PAUSE]) begin
							sr_q[flash_pkg::B_PAUSE] <= 1'b0; // RULE20
							sr_q[flash_pkg::B_BUSY] <= 1'b1;
						end
					end
					flash_pkg::OP_RST: begin
						// Soft reset reloads kept bits; a cut-off program or erase is a failure
						if (one && arm_q) begin
							sr_q <= nv_q; // RULE4 RULE20
							sr_q[flash_pkg::B_FAIL] <= sr_q[flash_pkg::B_FAIL] ||
								(prog_q && (sr_q[flash_pkg::B_BUSY] || sr_q[flash_pkg::B_PAUSE])); // RULE18
							bcnt_q <= 16'h0000;
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// ************************************************
	// Status read out
	// ************************************************
	assign rd_byte = (op_q == flash_pkg::OP_SR_HI) ? sr_q[15:8] : sr_q[7:0];

	// Live byte each pass, so polling sees busy fall; repeats while selected
	always_ff @(posedge i_clk_sys) begin
		if (i_reset || cs_s) begin
			link.d_o <= 4'h0;
			link.d_oe_n <= 4'hF;
			idx_q <= 3'h7;
		end else if (sck_fall && rd_q) begin // RULE8 RULE9
			if (qpi_q) begin
				link.d_o <= idx_q[2] ? rd_byte[7:4] : rd_byte[3:0]; // RULE21
				link.d_oe_n <= 4'h0;
				idx_q <= idx_q - 3'h4;
			end else begin
				link.d_o <= {2'h0, rd_byte[idx_q], 1'b0};
				link.d_oe_n <= 4'hD;
				idx_q <= idx_q - 3'h1;
			end
		end
	end

	assign o_status = sr_q;
	assign o_quad_cmd = qpi_q;
endmodule

// [hdl/flash_host_ctrl.sv]
`timescale 1ns/1ps
module flash_host_ctrl (
	flash_link_if.host link,
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr
);
	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_GAP} hstate_t;
	hstate_t st_q;
	logic [15:0] ctrl_q;
	logic [31:0] tx_q;
	logic [31:0] rx_q;
	logic [39:0] sh_q;
	logic [6:0] rem_q;
	logic [6:0] rxb_q;
	logic [6:0] stp;
	logic [3:0] div_q;
	logic quad_q;
	logic latch_q;
	logic vol_q;
	logic devbusy_q;
	logic refused_q;
	logic [3:0] io_s;
	logic ctrl_wr;
	logic go;
	logic [7:0] nop;

	// Opcodes that change content and need a fresh latch set
	function automatic logic changes(input logic [7:0] op);
		return (op == flash_pkg::OP_SRW) || (op == flash_pkg::OP_SRW_HI) || (op == flash_pkg::OP_PAGE) ||
			(op == flash_pkg::OP_SMALL) || (op == flash_pkg::OP_BLOCK) || (op == flash_pkg::OP_ARRAY) ||
			(op == flash_pkg::OP_SEC_WIPE) || (op == flash_pkg::OP_SEC_WR);
	endfunction

	function automatic logic [6:0] bits_of(input logic [3:0] n);
		return {n, 3'h0};
	endfunction

	// ************************************************
	// Register slave
	// ************************************************
	pin_sync #(.W(4), .INIT(4'hF)) u_sync (
		.i_clk_sys(i_clk_sys),
		.i_reset(i_reset),
		.i_async(link.io),
		.o_sync(io_s)
	);

	assign ctrl_wr = i_psel && i_penable && o_pready && i_pwrite && (i_paddr == flash_pkg::REG_CTRL);
	assign nop = i_pwdata[7:0];
	// Guarded start: no change without latch, nothing but polling or pause while busy
	assign go = ctrl_wr && i_pwdata[flash_pkg::CTRL_GO] && (st_q == ST_IDLE) &&
		// A status write right after the volatile enable needs no latch
		!(changes(nop) && !latch_q && !(vol_q && (nop == flash_pkg::OP_SRW || nop == flash_pkg::OP_SRW_HI))) && // RULE5 RULE7
		!(devbusy_q && (nop != flash_pkg::OP_SR_LO) && (nop != flash_pkg::OP_SR_HI) && (nop != flash_pkg::OP_PAUSE)); // RULE10

	// No wait state: ready in the cycle after setup
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata <= 32'h00000000;
		end else begin
			o_pready <= i_psel && !i_penable;
			o_pslverr <= i_psel && !i_penable && (i_paddr[1:0] != 2'h0 || i_paddr > flash_pkg::REG_STAT);
			case (i_paddr)
				flash_pkg::REG_CTRL: o_prdata <= {16'h0000, ctrl_q};
				flash_pkg::REG_TX: o_prdata <= tx_q;
				flash_pkg::REG_RX: o_prdata <= rx_q;
				flash_pkg::REG_STAT: o_prdata <= {29'h00000000, devbusy_q, refused_q, st_q != ST_IDLE};
				default: o_prdata <= 32'h00000000;
			endcase
		end
	end

	// Software registers; ignored while a frame runs
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			ctrl_q <= 16'h0000;
			tx_q <= 32'h00000000;
			refused_q <= 1'b0;
		end else if (i_psel && i_penable && o_pready && i_pwrite && st_q == ST_IDLE) begin
			if (i_paddr == flash_pkg::REG_CTRL) begin
				ctrl_q <= i_pwdata[15:0];
				refused_q <= i_pwdata[flash_pkg::CTRL_GO] && !go;
			end
			if (i_paddr == flash_pkg::REG_TX) begin
				tx_q <= i_pwdata;
			end
		end
	end

	// Latch and device-busy tracking from what was sent and read back
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			latch_q <= 1'b0;
			vol_q <= 1'b0;
			devbusy_q <= 1'b0;
		end else if (go) begin
			vol_q <= (nop == flash_pkg::OP_VOL_EN); // RULE7
			latch_q <= (nop == flash_pkg::OP_LATCH_SET) ||
				(latch_q && (nop == flash_pkg::OP_SR_LO || nop == flash_pkg::OP_SR_HI || nop == flash_pkg::OP_VOL_EN));
			devbusy_q <= devbusy_q || changes(nop);
		end else if (st_q == ST_GAP && ctrl_q[7:0] == flash_pkg::OP_SR_LO && rxb_q != 7'h00) begin
			devbusy_q <= rx_q[flash_pkg::B_BUSY]; // RULE10
		end
	end

	// ************************************************
	// Link engine
	// ************************************************
	assign stp = quad_q ? 7'h04 : 7'h01;

	// Frame: select low, opcode, bytes, select high
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			st_q <= ST_IDLE;
			link.cs_n <= 1'b1;
			link.sck <= 1'b0;
			link.h_o <= 4'h8;
			link.h_oe_n <= 4'h2;
			sh_q <= '0;
			rem_q <= 7'h00;
			rxb_q <= 7'h00;
			rx_q <= 32'h00000000;
			div_q <= 4'h0;
			quad_q <= 1'b0;
		end else begin
			unique case (st_q)
				ST_IDLE: begin
					link.h_o <= {1'b1, ctrl_q[flash_pkg::CTRL_GUARD], 1'b0, 1'b0};
					link.h_oe_n <= 4'h2;
					if (go) begin
						quad_q <= i_pwdata[flash_pkg::CTRL_QUAD];
						sh_q <= {nop, tx_q};
						rem_q <= bits_of(4'h1 + {1'b0, i_pwdata[flash_pkg::F_TX_LO +: 3]} +
							{1'b0, i_pwdata[flash_pkg::F_RX_LO +: 3]});
						rxb_q <= bits_of({1'b0, i_pwdata[flash_pkg::F_RX_LO +: 3]});
						rx_q <= 32'h00000000;
						link.cs_n <= 1'b0; // RULE2
						div_q <= 4'h0;
						link.h_o <= i_pwdata[flash_pkg::CTRL_QUAD] ? nop[7:4] :
							{1'b1, i_pwdata[flash_pkg::CTRL_GUARD], 1'b0, nop[7]}; // RULE21
						link.h_oe_n <= i_pwdata[flash_pkg::CTRL_QUAD] ? 4'h0 : 4'h2;
						st_q <= ST_RUN;
					end
				end
				ST_RUN: begin
					div_q <= div_q + 4'h1;
					if (div_q == flash_pkg::SCK_HALF - 4'h1) begin
						div_q <= 4'h0;
						link.sck <= !link.sck;
						// Falling edge ends a bit: sample, then present the next
						if (link.sck) begin
							if (rem_q <= rxb_q) begin
								rx_q <= quad_q ? {rx_q[27:0], io_s} : {rx_q[30:0], io_s[flash_pkg::SO_IO]};
							end
							rem_q <= rem_q - stp;
							sh_q <= quad_q ? {sh_q[35:0], 4'h0} : {sh_q[38:0], 1'b0};
							link.h_o <= quad_q ? sh_q[35:32] : {1'b1, ctrl_q[flash_pkg::CTRL_GUARD], 1'b0, sh_q[38]}; // RULE21
							if (quad_q && (rem_q - stp <= rxb_q)) begin
								link.h_oe_n <= 4'hF;
							end
							if (rem_q == stp) begin
								st_q <= ST_GAP;
							end
						end
					end
				end
				ST_GAP: begin
					div_q <= div_q + 4'h1;
					if (div_q == flash_pkg::SCK_HALF - 4'h1) begin
						div_q <= 4'h0;
						if (!link.cs_n) begin
							link.cs_n <= 1'b1; // RULE2
						end else begin
							st_q <= ST_IDLE;
						end
					end
				end
			endcase
		end
	end
endmodule

// [bench/flash_link_assertions.sv]
`timescale 1ns/1ps
// ****************************************
// Link checks seen from both ends
// ****************************************
module flash_link_assertions (
	input logic i_clk_sys,
	input logic i_reset,
	input logic cs_n,
	input logic sck,
	input logic [3:0] h_o,
	input logic [3:0] h_oe_n,
	input logic [3:0] d_o,
	input logic [3:0] d_oe_n,
	input logic [3:0] io
);
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_reset);
	// Select settles a half period before the first rise
	sequence lead_in;
		(!sck) [*8] ##1 sck;
	endsequence
	// High phase of a sixteen-cycle serial clock
	sequence high_pulse;
		sck [*8] ##1 !sck;
	endsequence
	sck_idle_a: assert property (cs_n |-> !sck) else $error("clock moved while deselected");
	frame_lead_a: assert property ($fell(cs_n) |-> lead_in) else $error("bad frame lead");
	sck_high_a: assert property ($rose(sck) |-> high_pulse) else $error("bad clock high time");
	cs_gap_a: assert property ($rose(cs_n) |-> cs_n [*8]) else $error("select gap too short");
	host_hold_a: assert property (sck && !cs_n |-> $stable(h_o)) else $error("host data moved");
	dev_hold_a: assert property (sck && $past(sck) |-> $stable(d_o)) else $error("device data moved");
	dev_release_a: assert property (cs_n [*6] |-> d_oe_n == 4'hF) else $error("device drove idle bus");
	no_clash_a: assert property ((h_oe_n | d_oe_n) == 4'hF) else $error("both ends drive a line");
endmodule

// [bench/tb_top.sv]
`timescale 1ns/1ps
// ****************************************
// Controller and device back to back
// ****************************************
module tb_top;
	logic i_clk_sys = 0, i_reset = 1, psel = 0, penable = 0, pwrite = 0, qd = 0, gd = 1, flt = 0;
	logic pready, pslverr, er, quad;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, st;
	logic [15:0] status;
	int fail_count = 0, tests_run = 0;
	flash_link_if lnk ();
	// Fault input raised for one erase only; the array wipe fails on protection, the rest succeed
	flash_status_dev flash_status_dev_i (.link(lnk), .i_clk_sys(i_clk_sys), .i_reset(i_reset),
		.i_op_fault(flt), .o_status(status), .o_quad_cmd(quad));
	flash_host_ctrl flash_host_ctrl_i (.link(lnk), .i_clk_sys(i_clk_sys), .i_reset(i_reset),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr));
	flash_link_assertions chk_i (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .cs_n(lnk.cs_n), .sck(lnk.sck),
		.h_o(lnk.h_o), .h_oe_n(lnk.h_oe_n), .d_o(lnk.d_o), .d_oe_n(lnk.d_oe_n), .io(lnk.io));
	// Free-running system clock
	always #2 i_clk_sys = ~i_clk_sys;
	task end_of_test;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task tmo(input logic hit);
		if (hit) begin
			fail_count++;
			end_of_test();
		end
	endtask
	task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
		tests_run++;
		if (s !== e) begin
			fail_count++;
			$display("MISMATCH %s exp %h seen %h", nm, e, s);
		end
	endtask
	// One APB transfer, then an idle cycle so psel is never driven twice at once
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clk_sys);
		penable <= 1;
		n = 0;
		do begin
			@(posedge i_clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge i_clk_sys);
		tmo(n >= 20);
	endtask
	// One link frame: load, go, wait for the frame to finish, fetch received bytes
	task op(input logic [7:0] c, input logic [2:0] nt, input logic [31:0] d, input logic [2:0] nr);
		int n;
		apb(1, flash_pkg::REG_TX, d);
		apb(1, flash_pkg::REG_CTRL, {1'b1, 15'h0, gd, qd, nr, nt, c});
		n = 0;
		do begin
			apb(0, flash_pkg::REG_STAT, 32'h0);
			n++;
		end while (rd[flash_pkg::STAT_RUN] !== 1'b0 && n < 900);
		st = rd;
		tmo(n >= 900);
		apb(0, flash_pkg::REG_RX, 32'h0);
	endtask
	// Poll the busy bit until clear
	task idle;
		int n;
		n = 0;
		do begin
			op(8'h05, 0, 0, 1);
			n++;
		end while (rd[0] !== 1'b0 && n < 40);
		tmo(n >= 40);
	endtask
	// Main sequence
	initial begin
		repeat (8) @(posedge i_clk_sys);
		i_reset <= 0;
		@(posedge i_clk_sys);
		chk("status", status, 16'h0000);
		apb(0, 8'h10, 32'h0);
		chk("slverr", 16'(er), 16'h0001);
		op(8'h06, 0, 0, 0);
		op(8'h05, 0, 0, 1);
		chk("read low", 16'(rd[7:0]), 16'h0002);
		op(8'h04, 0, 0, 0);
		chk("status", status, 16'h0000);
		op(8'h01, 2, 32'h0C000000, 0);
		chk("refused", 16'(st[1]), 16'h0001);
		chk("status", status, 16'h0000);
		op(8'h06, 0, 0, 0);
		op(8'h01, 2, 32'h0C000000, 0);
		chk("status", status, 16'h000F);
		idle();
		chk("status", status, 16'h000C);
		op(8'h06, 0, 0, 0);
		op(8'hC7, 0, 0, 0);
		chk("status", status, 16'h040C);
		idle();
		op(8'h35, 0, 0, 1);
		chk("read high", 16'(rd[7:0]), 16'h0004);
		op(8'h50, 0, 0, 0);
		op(8'h01, 2, 32'h80000000, 0);
		chk("status", status, 16'h0480);
		idle();
		gd <= 0;
		op(8'h06, 0, 0, 0);
		op(8'h01, 2, 32'h0, 0);
		idle();
		chk("lock", status & 16'h01FC, 16'h0080);
		gd <= 1;
		op(8'h06, 0, 0, 0);
		op(8'h01, 2, 32'h0, 0);
		idle();
		chk("lock", status & 16'h01FC, 16'h0000);
		op(8'h38, 0, 0, 0);
		chk("quad mode", 16'(quad), 16'h0001);
		qd <= 1;
		op(8'h35, 0, 0, 1);
		chk("quad read", 16'(rd[7:0]), 16'h0004);
		op(8'hFF, 0, 0, 0);
		chk("quad mode", 16'(quad), 16'h0000);
		qd <= 0;
		op(8'h06, 0, 0, 0);
		op(8'h20, 3, 32'h0, 0);
		op(8'h05, 0, 0, 1);
		chk("read low", 16'(rd[1:0]), 16'h0003);
		op(8'h75, 0, 0, 0);
		chk("paused", 16'(status[15]), 16'h0001);
		op(8'h05, 0, 0, 1);
		op(8'h7A, 0, 0, 0);
		chk("paused", 16'(status[15]), 16'h0000);
		idle();
		chk("status", status & 16'h0403, 16'h0000);
		flt <= 1;
		op(8'h06, 0, 0, 0);
		op(8'hD8, 3, 32'h0, 0);
		idle();
		chk("fail", 16'(status[10]), 16'h0001);
		flt <= 0;
		end_of_test();
	end
endmodule
